// *** src/window_ctrl_pkg.sv ***
// constants and carrier types for the window and sunroof controller
package window_ctrl_pkg;

  // ignition positions
  typedef enum logic [1:0] {
    IGN_OFF   = 2'h0,
    IGN_POS1  = 2'h1,
    IGN_POS2  = 2'h2,
    IGN_CRANK = 2'h3
  } ign_t;

  // cancel mode, fixed per market variant
  typedef enum logic [1:0] {
    CANCEL_DRIVER = 2'h0,
    CANCEL_ALL    = 2'h1,
    CANCEL_NONE   = 2'h2
  } cancel_mode_t;

  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned TICK_US      = 1000;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned TICK_W       = 17;

  localparam int unsigned POST_IGN_MS  = 44000;
  localparam int unsigned INRUSH_MS    = 500;
  localparam int unsigned STALL_MS     = 300;
  localparam int unsigned RUN_MAX_MS   = 10000;
  localparam int unsigned TOUCH_MS     = 400;
  localparam int unsigned MS_W         = 16;

  localparam logic [MS_W-1:0] POST_IGN_TICKS = MS_W'(POST_IGN_MS * 1000 / TICK_US);
  localparam logic [MS_W-1:0] INRUSH_TICKS   = MS_W'(INRUSH_MS * 1000 / TICK_US);
  localparam logic [MS_W-1:0] STALL_TICKS    = MS_W'(STALL_MS * 1000 / TICK_US);
  localparam logic [MS_W-1:0] RUN_MAX_TICKS  = MS_W'(RUN_MAX_MS * 1000 / TICK_US);
  localparam logic [MS_W-1:0] TOUCH_TICKS    = MS_W'(TOUCH_MS * 1000 / TICK_US);

  localparam int unsigned NUM_WIN   = 2;
  localparam int unsigned WIN_RIGHT = 0;
  localparam int unsigned WIN_LEFT  = 1;

  typedef struct packed {
    logic up;
    logic down;
    logic stall;
  } win_in_t;

  typedef struct packed {
    logic up;
    logic down;
  } win_out_t;

  typedef struct packed {
    logic rear_window_enable;
    logic sunroof_enable;
  } idm_req_t;

endpackage : window_ctrl_pkg

// *** src/window_motor_ctrl.sv ***
// one front window motor: direction, one-touch, stall and run timeout
`timescale 1ns/10ps
module window_motor_ctrl (
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  input  wire logic                       tick,
  input  wire logic                       allow,
  input  window_ctrl_pkg::win_in_t        sw_in,
  output window_ctrl_pkg::win_out_t       drive,
  output logic                            one_touch,
  output logic                            stalled,
  output logic                            timed_out
);

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_HELD  = 5'h02,
    ST_AUTO  = 5'h04,
    ST_GAP   = 5'h08,
    ST_LOCK  = 5'h10
  } mstate_t;

  typedef struct packed {
    mstate_t                             st;
    logic                                dir_up;
    logic [window_ctrl_pkg::MS_W-1:0]    run_cnt;
    logic [window_ctrl_pkg::MS_W-1:0]    stall_cnt;
    logic [window_ctrl_pkg::MS_W-1:0]    press_cnt;
    logic                                press_prev;
    logic                                stalled;
    logic                                timed_out;
    window_ctrl_pkg::win_out_t           drive;
  } mstate_pack_t;

  mstate_pack_t s_ff;
  mstate_pack_t nxt_s;

  logic pressed;
  logic want_up;
  logic run_over;
  logic stall_hit;

  // only one switch direction counts; both at once means no request
  assign pressed  = sw_in.up ^ sw_in.down;
  assign want_up  = sw_in.up;
  assign run_over = s_ff.run_cnt >= window_ctrl_pkg::RUN_MAX_TICKS;
  assign stall_hit = s_ff.stall_cnt > window_ctrl_pkg::STALL_TICKS;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.press_prev = pressed;
    nxt_s.drive = '0;
    if (tick && s_ff.drive != '0 && s_ff.run_cnt != '1) begin
      nxt_s.run_cnt = s_ff.run_cnt + 1'b1;
    end
    // stall current ignored during inrush
    if (tick && s_ff.drive != '0 && s_ff.run_cnt >= window_ctrl_pkg::INRUSH_TICKS) begin
      nxt_s.stall_cnt = sw_in.stall ? s_ff.stall_cnt + 1'b1 : '0;
    end
    if (tick && pressed && s_ff.press_cnt != '1) begin
      nxt_s.press_cnt = s_ff.press_cnt + 1'b1;
    end
    if (!pressed) begin
      nxt_s.press_cnt = '0;
    end
    case (s_ff.st)
      ST_IDLE: begin
        nxt_s.run_cnt   = '0;
        nxt_s.stall_cnt = '0;
        if (allow && pressed && !s_ff.press_prev) begin
          nxt_s.dir_up    = want_up;
          nxt_s.st        = ST_HELD;
          nxt_s.stalled   = 1'b0;
          nxt_s.timed_out = 1'b0;
        end
      end
      ST_HELD: begin
        if (!allow) begin
          nxt_s.st = ST_GAP;
        end else if (stall_hit) begin
          nxt_s.stalled = 1'b1;
          nxt_s.st      = ST_LOCK;
        end else if (run_over) begin
          nxt_s.timed_out = 1'b1;
          nxt_s.st        = ST_LOCK;
        end else if (!pressed) begin
          // short press on down starts one-touch lowering
          if (!s_ff.dir_up && s_ff.press_cnt < window_ctrl_pkg::TOUCH_TICKS) begin
            nxt_s.st = ST_AUTO;
            nxt_s.drive.down = 1'b1;
          end else begin
            nxt_s.st = ST_GAP;
          end
        end else if (want_up != s_ff.dir_up) begin
          nxt_s.st = ST_GAP;
        end else begin
          nxt_s.drive.up   = s_ff.dir_up;
          nxt_s.drive.down = !s_ff.dir_up;
        end
      end
      ST_AUTO: begin
        if (!allow) begin
          nxt_s.st = ST_GAP;
        end else if (stall_hit) begin
          nxt_s.stalled = 1'b1;
          nxt_s.st      = ST_GAP;
        end else if (run_over) begin
          nxt_s.timed_out = 1'b1;
          nxt_s.st        = ST_GAP;
        end else if (pressed && s_ff.press_cnt > window_ctrl_pkg::TOUCH_TICKS) begin
          nxt_s.st = ST_LOCK;
        end else begin
          nxt_s.drive.down = 1'b1;
        end
      end
      // one idle cycle with both outputs low before any new drive
      ST_GAP: begin
        nxt_s.st = ST_IDLE;
        nxt_s.press_prev = 1'b0;
        if (pressed) begin
          nxt_s.st = ST_LOCK;
        end
      end
      ST_LOCK: begin
        if (!pressed) begin
          nxt_s.st = ST_IDLE;
        end
      end
      default: begin
        nxt_s.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '{st: ST_IDLE, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign drive     = s_ff.drive;
  assign one_touch = s_ff.st == ST_AUTO;
  assign stalled   = s_ff.stalled;
  assign timed_out = s_ff.timed_out;

endmodule : window_motor_ctrl

// *** src/power_window_sunroof_control.sv ***
// front window, rear window and sunroof enable controller
// Notes on behaviour
// - cancel mode picks whether driver door, any door, or ignition off ends operation before 44 s.
// - windows and sunroof work in ignition position II and during the post-ignition time, and stop in crank.
// - each front window has separate up and down drives chosen from its switches.
// - rear window and sunroof enables follow window_allow (position II or post-ignition time) and drop in crank.
// - stall current is ignored for the first 500 ms of a motor run.
// - stall is current over threshold for more than 300 ms and cuts drive at once.
// - a motor driven one way for more than 10 s is stopped.
// - after timeout the motor restarts only on release and new press; one-touch resumes on next press.
// - a press shorter than 0.4 s starts one-touch lowering.
// - one-touch ends on stall, a re-press over 0.4 s, or 10 s run time.
// - operation stays allowed 44 s after ignition leaves position II, then stops.
// - the post-ignition timer cancels on driver door close or door open as the mode selects.
// - preconditions and cancel mode are fixed configuration, not run-time derived.
// - rear windows are controlled only by an enable request to the interior_door_module.
`timescale 1ns/10ps
module power_window_sunroof_control #(
  parameter window_ctrl_pkg::cancel_mode_t CANCEL_MODE = window_ctrl_pkg::CANCEL_DRIVER,
  parameter int unsigned                   TICK_CYCLES = window_ctrl_pkg::TICK_CYCLES
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  input  window_ctrl_pkg::ign_t           ignition,
  input  wire logic                       key_in,
  input  wire logic                       driver_door_open,
  input  wire logic                       other_door_open,
  input  window_ctrl_pkg::win_in_t        right_sw,
  input  window_ctrl_pkg::win_in_t        left_sw,
  output window_ctrl_pkg::win_out_t       right_drive,
  output window_ctrl_pkg::win_out_t       left_drive,
  output window_ctrl_pkg::idm_req_t       idm_req,
  output logic                            window_allow,
  output logic [1:0]                      one_touch,
  output logic [1:0]                      stalled,
  output logic [1:0]                      timed_out
);

  typedef struct packed {
    logic [window_ctrl_pkg::TICK_W-1:0] pre_cnt;
    logic                               tick;
    logic [window_ctrl_pkg::MS_W-1:0]   post_cnt;
    logic                               post_active;
    logic                               was_on;
    logic                               drv_open_seen;
    logic                               allow;
    window_ctrl_pkg::idm_req_t          req;
  } top_state_t;

  top_state_t s_ff;
  top_state_t nxt_s;

  // two-stage synchronisers for pin inputs
  localparam int unsigned SYNC_W = 2 + 1 + 1 + 1 + 3 + 3;
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  window_ctrl_pkg::ign_t   ign_s;
  logic                    key_s;
  logic                    drv_s;
  logic                    oth_s;
  window_ctrl_pkg::win_in_t sw_s [window_ctrl_pkg::NUM_WIN];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {ignition, key_in, driver_door_open, other_door_open, right_sw, left_sw};
      sync2_ff <= sync1_ff;
    end
  end

  assign ign_s = window_ctrl_pkg::ign_t'(sync2_ff[10:9]);
  assign key_s = sync2_ff[8];
  assign drv_s = sync2_ff[7];
  assign oth_s = sync2_ff[6];
  assign sw_s[window_ctrl_pkg::WIN_RIGHT] = sync2_ff[5:3];
  assign sw_s[window_ctrl_pkg::WIN_LEFT]  = sync2_ff[2:0];

  logic ign_on;
  logic crank;
  logic cancel_evt;

  assign ign_on = ign_s == window_ctrl_pkg::IGN_POS2;
  assign crank  = ign_s == window_ctrl_pkg::IGN_CRANK;

  // door event that ends post-ignition operation for the fixed mode
  always_comb begin
    case (CANCEL_MODE)
      window_ctrl_pkg::CANCEL_DRIVER: cancel_evt = s_ff.drv_open_seen && !drv_s;
      window_ctrl_pkg::CANCEL_ALL:    cancel_evt = oth_s || (s_ff.drv_open_seen && !drv_s);
      default:                        cancel_evt = 1'b1;
    endcase
  end

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (s_ff.pre_cnt >= window_ctrl_pkg::TICK_W'(TICK_CYCLES - 1)) begin
      nxt_s.pre_cnt = '0;
      nxt_s.tick    = 1'b1;
    end else begin
      nxt_s.pre_cnt = s_ff.pre_cnt + 1'b1;
    end
    nxt_s.was_on = ign_on;
    if (ign_on) begin
      nxt_s.post_active   = 1'b0;
      nxt_s.post_cnt      = '0;
      nxt_s.drv_open_seen = 1'b0;
    end else if (s_ff.was_on && !crank) begin
      nxt_s.post_active = CANCEL_MODE != window_ctrl_pkg::CANCEL_NONE;
      nxt_s.post_cnt    = '0;
    end else if (s_ff.post_active) begin
      if (drv_s) begin
        nxt_s.drv_open_seen = 1'b1;
      end
      if (s_ff.tick) begin
        nxt_s.post_cnt = s_ff.post_cnt + 1'b1;
      end
      // 44 s window runs from ignition leaving position II; early cancel by door events
      if (crank || cancel_evt || s_ff.post_cnt >= window_ctrl_pkg::POST_IGN_TICKS) begin
        nxt_s.post_active = 1'b0;
      end
    end
    if (key_s && !s_ff.post_active && !ign_on) begin
      nxt_s.post_cnt = '0;
    end
    // next post state keeps allow up across the ignition-off edge
    nxt_s.allow = !crank && (ign_on || nxt_s.post_active);
    nxt_s.req.rear_window_enable = nxt_s.allow;
    nxt_s.req.sunroof_enable     = nxt_s.allow;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  window_ctrl_pkg::win_out_t drv_w [window_ctrl_pkg::NUM_WIN];

  for (genvar i = 0; i < window_ctrl_pkg::NUM_WIN; i++) begin : g_win
    window_motor_ctrl u_motor (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .tick      (s_ff.tick),
      .allow     (s_ff.allow),
      .sw_in     (sw_s[i]),
      .drive     (drv_w[i]),
      .one_touch (one_touch[i]),
      .stalled   (stalled[i]),
      .timed_out (timed_out[i])
    );
  end

  assign right_drive  = drv_w[window_ctrl_pkg::WIN_RIGHT];
  assign left_drive   = drv_w[window_ctrl_pkg::WIN_LEFT];
  assign idm_req      = s_ff.req;
  assign window_allow = s_ff.allow;

endmodule : power_window_sunroof_control

// *** bench/window_motor_model.sv ***
// window motor model: inrush and end-of-travel current
`timescale 1ns/10ps
module window_motor_model #(
  parameter int unsigned INRUSH_CYC = 20
) (
  input  wire logic                 core_clk,
  input  window_ctrl_pkg::win_out_t drive,
  input  wire logic [31:0]          end_cyc,
  output logic                      stall
);
  logic [31:0] run_ff = '0;
  always_ff @(posedge core_clk) begin
    run_ff <= (drive == 2'h0) ? 32'h0 : run_ff + 32'h1;
  end
  // current only flows while driven
  assign stall = (drive != 2'h0) && (run_ff < INRUSH_CYC || run_ff >= end_cyc);
endmodule : window_motor_model

// *** bench/window_ctrl_checker.sv ***
// port assertions for the window controller
`timescale 1ns/10ps
module window_ctrl_checker #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  input  window_ctrl_pkg::ign_t     ignition,
  input  window_ctrl_pkg::win_in_t  right_sw,
  input  window_ctrl_pkg::win_out_t right_drive,
  input  window_ctrl_pkg::win_out_t left_drive,
  input  window_ctrl_pkg::idm_req_t idm_req,
  input  wire logic                 window_allow,
  input  wire logic [1:0]           stalled,
  input  wire logic [1:0]           timed_out
);
  localparam int unsigned STALL_MIN = (window_ctrl_pkg::INRUSH_TICKS + window_ctrl_pkg::STALL_TICKS - 2) * TICK_CYCLES;
  localparam int unsigned RUN_MAX   = (window_ctrl_pkg::RUN_MAX_TICKS + 2) * TICK_CYCLES;
  logic [31:0] run_ff;
  logic        idle_ff;
  // length of the current or last right motor run
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_ff  <= '0;
      idle_ff <= 1'b1;
    end else begin
      idle_ff <= (right_drive == 2'h0);
      if (right_drive != 2'h0) run_ff <= idle_ff ? 32'h1 : run_ff + 32'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_press;
    $rose(right_sw.up) && !right_sw.down && window_allow && right_drive == 2'h0;
  endsequence
  sequence s_hold;
    right_sw.up [*6];
  endsequence
  a_press_drives_up: assert property (s_press ##0 s_hold |-> right_drive.up)
    else $error("held up press gave no up drive");
  a_right_never_both: assert property (!(right_drive.up && right_drive.down))
    else $error("right motor driven both ways");
  a_left_never_both: assert property (!(left_drive.up && left_drive.down))
    else $error("left motor driven both ways");
  a_reverse_gap: assert property (right_drive != 2'h0 |=> right_drive == $past(right_drive) || right_drive == 2'h0)
    else $error("right motor reversed without a gap");
  a_crank_stops: assert property (ignition == window_ctrl_pkg::IGN_CRANK [*5] |->
    !window_allow && idm_req == 2'h0 && right_drive == 2'h0 && left_drive == 2'h0)
    else $error("operation not suspended in crank");
  a_pos2_enables: assert property (ignition == window_ctrl_pkg::IGN_POS2 [*5] |-> idm_req == 2'h3 && window_allow)
    else $error("enables not on in position two");
  a_stall_late: assert property ($rose(stalled[0]) |-> run_ff > STALL_MIN && right_drive == 2'h0)
    else $error("stall taken too early or drive kept");
  a_run_limit: assert property (run_ff <= RUN_MAX)
    else $error("right motor ran past the run limit");
  a_timeout_cuts: assert property ($rose(timed_out[0]) |-> right_drive == 2'h0)
    else $error("timeout left drive on");
endmodule : window_ctrl_checker
bind power_window_sunroof_control window_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .core_clk(core_clk), .rst_b(rst_b), .ignition(ignition), .right_sw(right_sw), .right_drive(right_drive),
  .left_drive(left_drive), .idm_req(idm_req), .window_allow(window_allow), .stalled(stalled),
  .timed_out(timed_out));

// *** bench/power_window_sunroof_control_bench.sv ***
// self-checking bench for the window controller
`timescale 1ns/10ps
module power_window_sunroof_control_bench;
  typedef struct {string name; logic [7:0] exp;} note_t;
  logic                      core_clk = 1'b0;
  logic                      rst_b = 1'b0;
  window_ctrl_pkg::ign_t     ignition = window_ctrl_pkg::IGN_OFF;
  logic                      key_in = 1'b0;
  logic                      driver_door_open = 1'b0;
  logic                      other_door_open = 1'b0;
  logic                      r_up = 1'b0, r_dn = 1'b0, l_up = 1'b0, l_dn = 1'b0, r_st, l_st;
  logic [31:0]               r_end = 32'hFFFFFFFF, l_end = 32'hFFFFFFFF, seed = 32'h99B7DBE5;
  window_ctrl_pkg::win_out_t right_drive, left_drive;
  window_ctrl_pkg::idm_req_t idm_req;
  logic                      window_allow;
  logic                      rear_relay = 1'b0, link_ok = 1'b1;
  logic [1:0]                one_touch, stalled, timed_out;
  int                        err_count = 0, checks_done = 0, cyc = 0;
  note_t                     notes[$];
  event                      sample_ev;
  power_window_sunroof_control #(.CANCEL_MODE(window_ctrl_pkg::CANCEL_DRIVER), .TICK_CYCLES(4)) dut_u (
    .core_clk(core_clk), .rst_b(rst_b), .ignition(ignition), .key_in(key_in),
    .driver_door_open(driver_door_open), .other_door_open(other_door_open),
    .right_sw({r_up, r_dn, r_st}), .left_sw({l_up, l_dn, l_st}), .right_drive(right_drive),
    .left_drive(left_drive), .idm_req(idm_req), .window_allow(window_allow), .one_touch(one_touch),
    .stalled(stalled), .timed_out(timed_out));
  window_motor_model r_mdl (.core_clk(core_clk), .drive(right_drive), .end_cyc(r_end), .stall(r_st));
  window_motor_model l_mdl (.core_clk(core_clk), .drive(left_drive), .end_cyc(l_end), .stall(l_st));
  always #4 core_clk = ~core_clk;
  // door module rear relay: holds on a dead link until ignition off
  always @(posedge core_clk) begin
    if (link_ok) rear_relay <= idm_req.rear_window_enable;
    else if (ignition == window_ctrl_pkg::IGN_OFF) rear_relay <= 1'b0;
  end
  task automatic results();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      err_count = err_count + 1;
      results();
    end
  end
  function automatic logic [7:0] pick(string n);
    case (n)
      "allow": return {7'h0, window_allow};
      "idm":   return {6'h0, idm_req};
      "rdrv":  return {6'h0, right_drive};
      "ldrv":  return {6'h0, left_drive};
      "touch": return {6'h0, one_touch};
      "relay": return {7'h0, rear_relay};
      "stall": return {6'h0, stalled};
      default: return {6'h0, timed_out};
    endcase
  endfunction : pick
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic check(string n, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  always @(sample_ev) begin
    note_t nt;
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      check(nt.name, pick(nt.name), nt.exp);
    end
  end
  task automatic want(string n, logic [7:0] exp);
    note_t nt;
    nt.name = n;
    nt.exp = exp;
    notes.push_back(nt);
    -> sample_ev;
  endtask : want
  task automatic ncyc(int n);
    repeat (n) @(negedge core_clk);
  endtask : ncyc
  task automatic wait_for(string n, logic [7:0] exp, int max);
    for (int i = 0; i < max && pick(n) !== exp; i++) @(negedge core_clk);
    want(n, exp);
  endtask : wait_for
  initial begin
    ncyc(3);
    rst_b = 1'b1;
    ncyc(2);
    want("allow", 8'h00);
    key_in = 1'b1;
    ignition = window_ctrl_pkg::IGN_POS2;
    ncyc(6);
    want("allow", 8'h01);
    want("idm", 8'h03);
    r_up = 1'b1;
    ncyc(8);
    want("rdrv", 8'h02);
    ncyc(2000);
    r_up = 1'b0;
    ncyc(6);
    want("rdrv", 8'h00);
    want("touch", 8'h00);
    // short left press of random length, window then reaches its end
    seed = xs(seed);
    l_end = 32'd5000;
    l_dn = 1'b1;
    ncyc(20 + int'(seed % 32'd1000));
    l_dn = 1'b0;
    ncyc(6);
    want("touch", 8'h02);
    want("ldrv", 8'h01);
    wait_for("stall", 8'h02, 12000);
    want("ldrv", 8'h00);
    want("touch", 8'h00);
    r_dn = 1'b1;
    wait_for("tmo", 8'h01, 42000);
    want("rdrv", 8'h00);
    ncyc(50);
    want("rdrv", 8'h00);
    r_dn = 1'b0;
    ncyc(6);
    r_dn = 1'b1;
    ncyc(8);
    want("rdrv", 8'h01);
    want("tmo", 8'h00);
    r_dn = 1'b0;
    ncyc(6);
    want("touch", 8'h01);
    r_up = 1'b1;
    ncyc(2000);
    want("rdrv", 8'h00);
    want("touch", 8'h00);
    r_up = 1'b0;
    {l_up, l_dn} = 2'b11;
    ncyc(10);
    want("ldrv", 8'h00);
    {l_up, l_dn} = 2'b00;
    // held right run into its end stop
    r_end = 32'd3000;
    r_dn = 1'b1;
    wait_for("stall", 8'h03, 6000);
    want("rdrv", 8'h00);
    r_dn = 1'b0;
    link_ok = 1'b0;
    ignition = window_ctrl_pkg::IGN_CRANK;
    ncyc(6);
    want("allow", 8'h00);
    want("idm", 8'h00);
    want("relay", 8'h01);
    r_up = 1'b1;
    ncyc(8);
    want("rdrv", 8'h00);
    r_up = 1'b0;
    ignition = window_ctrl_pkg::IGN_POS2;
    ncyc(6);
    ignition = window_ctrl_pkg::IGN_OFF;
    key_in = 1'b0;
    ncyc(200);
    want("allow", 8'h01);
    want("relay", 8'h00);
    other_door_open = 1'b1;
    driver_door_open = 1'b1;
    ncyc(20);
    want("allow", 8'h01);
    driver_door_open = 1'b0;
    wait_for("allow", 8'h00, 20);
    ncyc(1);
    results();
  end
endmodule : power_window_sunroof_control_bench
